// ---- rtl/pbl_consts.vh ----
// Register offsets, field positions and reset values of the blocking logic.
`ifndef PBL_CONSTS_VH
`define PBL_CONSTS_VH
`define PBL_NUM_ELEM 8
`define PBL_NUM_SRC 16
`define PBL_OFF_MAIN 8'h00
`define PBL_OFF_ENA 8'h04
`define PBL_OFF_EXPERM 8'h08
`define PBL_OFF_TOPERM 8'h0C
`define PBL_OFF_TOBLK 8'h10
`define PBL_OFF_SUPV 8'h14
`define PBL_OFF_SELA 8'h18
`define PBL_OFF_SELB 8'h1C
`define PBL_OFF_STAT 8'h20
`define PBL_OFF_IRQ 8'h24
`define PBL_OFF_MASK 8'h28
`define PBL_OFF_SELT 8'h2C
`define PBL_OFF_MSEL 8'h30
`define PBL_BIT_ACTIVE 0
`define PBL_BIT_EXPERM 1
`define PBL_BIT_TOBLK 2
`define PBL_BIT_TOPERM 3
`define PBL_IRQ_TRIP 0
`define PBL_IRQ_ALARM 1
`define PBL_IRQ_BLOCK 2
`define PBL_IRQ_GND 3
`define PBL_MAIN_RST 32'h00000001
`define PBL_RESP_OKAY 2'h0
`define PBL_RESP_SLVERR 2'h2
`endif

// ---- rtl/pbl_top.v ----
// Protection blocking logic: trip and alarm combining, blocking, register bus.
// Operation
// RULE1: General trip ORs enabled authorised element trips.
// RULE2: Per-phase collective alarm ORs phase alarms.
// RULE3: Ground collective alarm ORs ground alarms.
// RULE4: Master switch inactive suppresses all protection.
// RULE5: Element switch inactive disables that element.
// RULE6: Permanent block stops element trip order.
// RULE7: Master blocking inputs need master permit.
// RULE8: Master blocking holds only while signal active.
// RULE9: Element blocking ORs two permitted inputs.
// RULE10: Blocking acts only while input asserted.
// RULE11: Trip order block input needs permit.
// RULE12: Any assignment list signal can block. Here assign_src[0] cannot, as code 0 means no assignment.
// RULE13: Supervision-only elements stay local, no order.
// RULE14: General alarm ORs non-supervision element alarms.
// RULE15: Master takes two blocking inputs, ORed.
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pbl_consts.vh"
module pbl_top #(
  parameter NE = `PBL_NUM_ELEM,
  parameter NS = `PBL_NUM_SRC
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write channels
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read channels
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Element decisions, one bit per element
  input wire [NE-1:0] elem_trip,
  input wire [NE-1:0] elem_alarm,
  input wire [NE-1:0] elem_alarm_l1,
  input wire [NE-1:0] elem_alarm_l2,
  input wire [NE-1:0] elem_alarm_l3,
  input wire [NE-1:0] elem_alarm_gnd,
  // Assignment list sources
  input wire [NS-1:0] assign_src,
  // Element gating back to the elements
  output reg [NE-1:0] elem_active,
  output reg [NE-1:0] trip_order_out,
  // Collective outputs
  output reg general_trip,
  output reg general_alarm,
  output reg collective_alarm_phase_one,
  output reg collective_alarm_phase_two,
  output reg collective_alarm_phase_three,
  output reg collective_alarm_ground,
  output reg irq
);

// ----------------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------------
reg [NS-1:0] src_m_r, src_r;
reg [NE-1:0] trp_m_r, trp_r, alm_m_r, alm_r;
reg [NE-1:0] l1_m_r, l1_r, l2_m_r, l2_r, l3_m_r, l3_r, g_m_r, g_r;
always @(posedge aclk)
begin
  src_m_r <= assign_src;
  src_r <= src_m_r;
  trp_m_r <= elem_trip;
  trp_r <= trp_m_r;
  alm_m_r <= elem_alarm;
  alm_r <= alm_m_r;
  l1_m_r <= elem_alarm_l1;
  l1_r <= l1_m_r;
  l2_m_r <= elem_alarm_l2;
  l2_r <= l2_m_r;
  l3_m_r <= elem_alarm_l3;
  l3_r <= l3_m_r;
  g_m_r <= elem_alarm_gnd;
  g_r <= g_m_r;
end

// ----------------------------------------------------------------------
// Configuration registers
// ----------------------------------------------------------------------
reg [31:0] main_r;
reg [NE-1:0] ena_r, experm_r, toperm_r, toblk_r, supv_r;
reg [4*NE-1:0] sela_r, selb_r, selt_r;
reg [15:0] msel_r;
reg [3:0] stat_r, mask_r;

// Selects one source; code 0 means no assignment.
function src_pick;
  input [3:0] code;
  input [NS-1:0] src;
  begin
    src_pick = (code != 4'h0) & src[code];
  end
endfunction

// ----------------------------------------------------------------------
// Blocking and combining
// ----------------------------------------------------------------------
reg master_blk, prot_on;
reg [NE-1:0] blk, tblk, act, loc_trip, fwd;
integer i;
always @*
begin
  // RULE15: master two inputs
  // RULE7: master permit gate
  // RULE8: level held block
  master_blk = main_r[`PBL_BIT_EXPERM] &
    (src_pick(msel_r[3:0], src_r) | src_pick(msel_r[7:4], src_r));
  // RULE4: master switch gate
  prot_on = main_r[`PBL_BIT_ACTIVE] & ~master_blk;
  for (i = 0; i < NE; i = i + 1)
  begin
    // RULE12: assignment list sources
    // RULE9: ORed permitted inputs
    // RULE10: level only block
    blk[i] = experm_r[i] & (src_pick(sela_r[4*i +: 4], src_r) |
      src_pick(selb_r[4*i +: 4], src_r));
    // RULE11: permitted order block
    tblk[i] = (toperm_r[i] & src_pick(selt_r[4*i +: 4], src_r)) |
      (main_r[`PBL_BIT_TOPERM] & src_pick(msel_r[11:8], src_r));
  end
  // RULE5: element switch gate
  act = {NE{prot_on}} & ena_r & ~blk;
  loc_trip = act & trp_r;
  // RULE13: supervision stays local
  fwd = act & ~supv_r;
  // RULE6: permanent order block
  tblk = tblk | toblk_r | {NE{main_r[`PBL_BIT_TOBLK]}};
end

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    elem_active <= {NE{1'b0}};
    trip_order_out <= {NE{1'b0}};
    general_trip <= 1'b0;
    general_alarm <= 1'b0;
    collective_alarm_phase_one <= 1'b0;
    collective_alarm_phase_two <= 1'b0;
    collective_alarm_phase_three <= 1'b0;
    collective_alarm_ground <= 1'b0;
  end
  else
  begin
    elem_active <= act;
    // RULE6: order needs unblocked trip
    trip_order_out <= fwd & loc_trip & ~tblk;
    // RULE1: general trip OR
    general_trip <= |(fwd & trp_r);
    // RULE14: general alarm OR
    general_alarm <= |(fwd & alm_r);
    // RULE2: phase alarm OR
    collective_alarm_phase_one <= |(fwd & l1_r);
    collective_alarm_phase_two <= |(fwd & l2_r);
    collective_alarm_phase_three <= |(fwd & l3_r);
    // RULE3: ground alarm OR
    collective_alarm_ground <= |(fwd & g_r);
  end
end

// ----------------------------------------------------------------------
// AXI4-Lite write path
// ----------------------------------------------------------------------
reg aw_hold_r, w_hold_r;
reg [7:0] aw_addr_r;
reg [31:0] w_data_r;
wire do_wr = aw_hold_r & w_hold_r & ~s_axi_bvalid;
wire [3:0] ev = {collective_alarm_ground, master_blk,
  general_alarm, general_trip};
reg [3:0] w1c;
always @*
begin
  w1c = 4'h0;
  if (do_wr && aw_addr_r == `PBL_OFF_IRQ)
    w1c = w_data_r[3:0];
end

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    aw_hold_r <= 1'b0;
    w_hold_r <= 1'b0;
    aw_addr_r <= 8'h00;
    w_data_r <= 32'h00000000;
    s_axi_awready <= 1'b0;
    s_axi_wready <= 1'b0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= 2'h0;
    main_r <= `PBL_MAIN_RST;
    ena_r <= {NE{1'b0}};
    experm_r <= {NE{1'b0}};
    toperm_r <= {NE{1'b0}};
    toblk_r <= {NE{1'b0}};
    supv_r <= {NE{1'b0}};
    sela_r <= {4*NE{1'b0}};
    selb_r <= {4*NE{1'b0}};
    selt_r <= {4*NE{1'b0}};
    msel_r <= 16'h0000;
    stat_r <= 4'h0;
    mask_r <= 4'h0;
    irq <= 1'b0;
  end
  else
  begin
    s_axi_awready <= ~aw_hold_r & ~s_axi_awready & s_axi_awvalid;
    s_axi_wready <= ~w_hold_r & ~s_axi_wready & s_axi_wvalid;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_r <= 1'b1;
      w_data_r <= s_axi_wdata;
    end
    if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
    if (do_wr)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= `PBL_RESP_OKAY;
      case (aw_addr_r)
        `PBL_OFF_MAIN: main_r <= {28'h0000000, w_data_r[3:0]};
        `PBL_OFF_ENA: ena_r <= w_data_r[NE-1:0];
        `PBL_OFF_EXPERM: experm_r <= w_data_r[NE-1:0];
        `PBL_OFF_TOPERM: toperm_r <= w_data_r[NE-1:0];
        `PBL_OFF_TOBLK: toblk_r <= w_data_r[NE-1:0];
        `PBL_OFF_SUPV: supv_r <= w_data_r[NE-1:0];
        `PBL_OFF_SELA: sela_r <= w_data_r[4*NE-1:0];
        `PBL_OFF_SELB: selb_r <= w_data_r[4*NE-1:0];
        `PBL_OFF_SELT: selt_r <= w_data_r[4*NE-1:0];
        `PBL_OFF_MSEL: msel_r <= w_data_r[15:0];
        `PBL_OFF_MASK: mask_r <= w_data_r[3:0];
        `PBL_OFF_IRQ: ;
        default: s_axi_bresp <= `PBL_RESP_SLVERR;
      endcase
    end
    // Events set sticky bits; a set beats a clear in the same cycle.
    stat_r <= (stat_r & ~w1c) | ev;
    irq <= |(stat_r & mask_r);
  end
end

// ----------------------------------------------------------------------
// AXI4-Lite read path
// ----------------------------------------------------------------------
reg [31:0] rd;
always @*
begin
  rd = 32'h00000000;
  case (s_axi_araddr)
    `PBL_OFF_MAIN: rd = main_r;
    `PBL_OFF_ENA: rd[NE-1:0] = ena_r;
    `PBL_OFF_EXPERM: rd[NE-1:0] = experm_r;
    `PBL_OFF_TOPERM: rd[NE-1:0] = toperm_r;
    `PBL_OFF_TOBLK: rd[NE-1:0] = toblk_r;
    `PBL_OFF_SUPV: rd[NE-1:0] = supv_r;
    `PBL_OFF_SELA: rd[4*NE-1:0] = sela_r;
    `PBL_OFF_SELB: rd[4*NE-1:0] = selb_r;
    `PBL_OFF_SELT: rd[4*NE-1:0] = selt_r;
    `PBL_OFF_MSEL: rd[15:0] = msel_r;
    `PBL_OFF_STAT: rd = {8'h00, loc_trip, trip_order_out, elem_active};
    `PBL_OFF_IRQ: rd[3:0] = stat_r;
    `PBL_OFF_MASK: rd[3:0] = mask_r;
    default: rd = 32'h00000000;
  endcase
end

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    s_axi_arready <= 1'b0;
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h00000000;
    s_axi_rresp <= 2'h0;
  end
  else
  begin
    s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd;
      s_axi_rresp <= (s_axi_araddr > `PBL_OFF_MSEL ||
        s_axi_araddr[1:0] != 2'h0) ? `PBL_RESP_SLVERR : `PBL_RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
end

endmodule // pbl_top

// ---- tb/pbl_src_model.sv ----
// Model of the protection elements and assignment list sources.
`timescale 1ns/1ps
module pbl_src_model #(
  parameter NE = 8,
  parameter NS = 16
) (
  // Clock
  input wire aclk,
  // Requested levels
  input wire [6*NE+NS-1:0] req,
  // Element decisions and sources
  output reg [NE-1:0] elem_trip = 0,
  output reg [NE-1:0] elem_alarm = 0,
  output reg [NE-1:0] elem_alarm_l1 = 0,
  output reg [NE-1:0] elem_alarm_l2 = 0,
  output reg [NE-1:0] elem_alarm_l3 = 0,
  output reg [NE-1:0] elem_alarm_gnd = 0,
  output reg [NS-1:0] assign_src = 0
);
  // Levels follow the request one edge later.
  always @(posedge aclk)
  begin
    {elem_trip, elem_alarm, elem_alarm_l1, elem_alarm_l2, elem_alarm_l3,
      elem_alarm_gnd, assign_src} <= req;
  end
endmodule // pbl_src_model

// ---- tb/pbl_props.sv ----
// Assertions on the ports of the protection blocking logic.
`timescale 1ns/1ps
module pbl_props #(
  parameter NE = 8
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Element decisions
  input wire [NE-1:0] elem_trip,
  input wire [NE-1:0] elem_alarm,
  input wire [NE-1:0] elem_alarm_l1,
  input wire [NE-1:0] elem_alarm_l2,
  input wire [NE-1:0] elem_alarm_gnd,
  // Combined outputs
  input wire [NE-1:0] elem_active,
  input wire [NE-1:0] trip_order_out,
  input wire general_trip,
  input wire general_alarm,
  input wire collective_alarm_phase_one,
  input wire collective_alarm_phase_two,
  input wire collective_alarm_ground,
  input wire irq
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  trip_cause_a: assert property (
    general_trip |-> $past(elem_trip, 3) != 0)
    else $error("general trip without element trip");
  order_cause_a: assert property (
    (trip_order_out & ~$past(elem_trip, 3)) == 0)
    else $error("trip order without trip");
  order_gen_a: assert property (
    trip_order_out != 0 |-> general_trip)
    else $error("trip order outside general trip");
  order_active_a: assert property (
    (trip_order_out & ~elem_active) == 0)
    else $error("trip order from inactive element");
  phase_one_a: assert property (
    collective_alarm_phase_one |-> $past(elem_alarm_l1, 3) != 0)
    else $error("phase one alarm without cause");
  phase_two_a: assert property (
    collective_alarm_phase_two |-> $past(elem_alarm_l2, 3) != 0)
    else $error("phase two alarm without cause");
  ground_cause_a: assert property (
    collective_alarm_ground |-> $past(elem_alarm_gnd, 3) != 0)
    else $error("ground alarm without cause");
  alarm_cause_a: assert property (
    general_alarm |-> $past(elem_alarm, 3) != 0)
    else $error("general alarm without cause");
  gen_active_a: assert property (
    general_trip || general_alarm |-> elem_active != 0)
    else $error("general output with no active element");
  cover property (general_trip);
  cover property (collective_alarm_ground);
  cover property (irq);
endmodule // pbl_props
bind pbl_top pbl_props #(.NE(NE)) pbl_props_inst (.aclk, .aresetn, .elem_trip,
  .elem_alarm, .elem_alarm_l1, .elem_alarm_l2, .elem_alarm_gnd, .elem_active,
  .trip_order_out, .general_trip, .general_alarm, .collective_alarm_phase_one,
  .collective_alarm_phase_two, .collective_alarm_ground, .irq);

// ---- tb/test_protection_blocking_logic.sv ----
// Self-checking bench for the protection blocking logic.
`timescale 1ns/1ps
`include "pbl_consts.vh"
module test_protection_blocking_logic;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [7:0] aw = 0, ar = 0, tr = 0, al = 0, a1 = 0, a2 = 0, a3 = 0, ag = 0;
  logic [31:0] wd = 0;
  logic [15:0] src = 0;
  wire awr, wrd, bv, arr, rv, gt, ga, c1, c2, c3, cg, irq;
  wire [1:0] br, rr;
  wire [31:0] rdt;
  wire [7:0] et, ea, e1, e2, e3, eg, act, tord;
  wire [15:0] asrc;
  int fail_count = 0, total_checks = 0, cyc = 0;
  initial
  begin
    forever #10 aclk = ~aclk;
  end
  pbl_src_model pbl_src_model_inst (.aclk(aclk),
    .req({tr, al, a1, a2, a3, ag, src}), .elem_trip(et), .elem_alarm(ea),
    .elem_alarm_l1(e1), .elem_alarm_l2(e2), .elem_alarm_l3(e3),
    .elem_alarm_gnd(eg), .assign_src(asrc));
  pbl_top pbl_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .elem_trip(et), .elem_alarm(ea), .elem_alarm_l1(e1),
    .elem_alarm_l2(e2), .elem_alarm_l3(e3), .elem_alarm_gnd(eg),
    .assign_src(asrc), .elem_active(act), .trip_order_out(tord),
    .general_trip(gt), .general_alarm(ga), .collective_alarm_phase_one(c1),
    .collective_alarm_phase_two(c2), .collective_alarm_phase_three(c3),
    .collective_alarm_ground(cg), .irq(irq));
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input [31:0] s, input [31:0] x);
    total_checks++;
    if (s !== x)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task st;
    repeat (6) @(posedge aclk);
  endtask
  task ck(input [7:0] a, input [7:0] t, input g);
    st;
    chk({act, tord}, {a, t});
    chk(gt, g);
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] e);
    aw <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    do
    begin
      @(posedge aclk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end
    while (!bv);
    bre <= 0;
    chk(br, e);
    @(posedge aclk);
  endtask
  task rd(input [7:0] a, input [31:0] d, input [1:0] e);
    ar <= a;
    arv <= 1;
    rre <= 1;
    do
    begin
      @(posedge aclk);
      if (arr) arv <= 0;
    end
    while (!rv);
    rre <= 0;
    chk(rdt, d);
    chk(rr, e);
    @(posedge aclk);
  endtask
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      conclude;
    end
  end
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(`PBL_OFF_MAIN, `PBL_MAIN_RST, `PBL_RESP_OKAY);
    rd(`PBL_OFF_ENA, 32'h0, `PBL_RESP_OKAY);
    wr(`PBL_OFF_ENA, 32'hFF, `PBL_RESP_OKAY);
    tr <= 8'h05;
    ck(8'hFF, 8'h05, 1'h1);
    wr(`PBL_OFF_TOBLK, 32'h1, `PBL_RESP_OKAY);
    ck(8'hFF, 8'h04, 1'h1);
    wr(`PBL_OFF_SELT, 32'h300, `PBL_RESP_OKAY);
    src <= 16'h0008;
    ck(8'hFF, 8'h04, 1'h1);
    wr(`PBL_OFF_TOPERM, 32'h4, `PBL_RESP_OKAY);
    ck(8'hFF, 8'h00, 1'h1);
    src <= 16'h0;
    ck(8'hFF, 8'h04, 1'h1);
    wr(`PBL_OFF_SUPV, 32'h5, `PBL_RESP_OKAY);
    ck(8'hFF, 8'h00, 1'h0);
    wr(`PBL_OFF_SUPV, 32'h0, `PBL_RESP_OKAY);
    {al, a1, a2, a3, ag} <= {8'h02, 8'h01, 8'h02, 8'h04, 8'h08};
    st;
    chk({ga, c1, c2, c3, cg}, 5'h1F);
    wr(`PBL_OFF_SELA, 32'h5, `PBL_RESP_OKAY);
    src <= 16'h0020;
    ck(8'hFF, 8'h04, 1'h1);
    wr(`PBL_OFF_EXPERM, 32'h3, `PBL_RESP_OKAY);
    ck(8'hFE, 8'h04, 1'h1);
    wr(`PBL_OFF_SELB, 32'h60, `PBL_RESP_OKAY);
    src <= 16'h0040;
    ck(8'hFD, 8'h04, 1'h1);
    src <= 16'h0;
    ck(8'hFF, 8'h04, 1'h1);
    wr(`PBL_OFF_MSEL, 32'h70, `PBL_RESP_OKAY);
    src <= 16'h0080;
    ck(8'hFF, 8'h04, 1'h1);
    wr(`PBL_OFF_MAIN, 32'h3, `PBL_RESP_OKAY);
    ck(8'h00, 8'h00, 1'h0);
    src <= 16'h0;
    ck(8'hFF, 8'h04, 1'h1);
    wr(`PBL_OFF_MAIN, 32'h5, `PBL_RESP_OKAY);
    ck(8'hFF, 8'h00, 1'h1);
    wr(`PBL_OFF_MAIN, 32'h9, `PBL_RESP_OKAY);
    wr(`PBL_OFF_MSEL, 32'h970, `PBL_RESP_OKAY);
    src <= 16'h0200;
    ck(8'hFF, 8'h00, 1'h1);
    src <= 16'h0;
    wr(`PBL_OFF_MAIN, 32'h0, `PBL_RESP_OKAY);
    ck(8'h00, 8'h00, 1'h0);
    chk({ga, c1, c2, c3, cg}, 5'h0);
    wr(`PBL_OFF_MAIN, 32'h1, `PBL_RESP_OKAY);
    wr(`PBL_OFF_ENA, 32'hFB, `PBL_RESP_OKAY);
    ck(8'hFB, 8'h00, 1'h1);
    wr(`PBL_OFF_MASK, 32'h1, `PBL_RESP_OKAY);
    st;
    chk(irq, 1'h1);
    rd(`PBL_OFF_IRQ, 32'hF, `PBL_RESP_OKAY);
    {tr, al, a1, a2, a3, ag} <= 48'h0;
    st;
    wr(`PBL_OFF_IRQ, 32'hFFFFFFFF, `PBL_RESP_OKAY);
    st;
    rd(`PBL_OFF_IRQ, 32'h0, `PBL_RESP_OKAY);
    chk(irq, 1'h0);
    wr(8'h40, 32'h1, `PBL_RESP_SLVERR);
    rd(8'h40, 32'h0, `PBL_RESP_SLVERR);
    conclude;
  end
endmodule // test_protection_blocking_logic
